// *** testbench/lc2_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module lc2_asserts
  import lc2_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  cfg_addr,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [15:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        fund_reset,
  input wire logic        hot_reset,
  input wire logic        downstream,
  input wire lc2_ltssm_e  ltssm_state,
  input wire logic [3:0]  cur_speed,
  input wire logic        low_swing,
  input wire logic [3:0]  adv_max_speed,
  input wire logic        compliance_req,
  input wire logic [3:0]  compliance_speed,
  input wire logic        tx_deemph_3p5,
  input wire logic [2:0]  tx_margin,
  input wire logic        tx_margin_normal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ts_stable_a: assert property (
    !cfg_wr && !fund_reset |=> $stable(compliance_speed)) else $error("speed moved unasked");
  ts_write_a: assert property (
    cfg_wr && cfg_addr == LC2_OFF_LCTL2 |=> compliance_speed == $past(cfg_wdata[3:0]))
    else $error("speed not taken from write");
  adv_cap_a: assert property (
    adv_max_speed == (downstream ? compliance_speed : LC2_SPEED_5G0)) else $error("bad cap");
  cmp_enter_a: assert property (
    $rose(compliance_req) |-> $past(hot_reset)) else $error("compliance without hot reset");
  asd_zero_a: assert property (
    cfg_rd && cfg_addr == LC2_OFF_LCTL2 |=> cfg_rdata[LC2_ASD_BIT] == 1'b0)
    else $error("autonomous disable reads one");
  de_hold_a: assert property (
    $changed(tx_deemph_3p5) && $stable(cur_speed) && $stable(low_swing) && $stable(downstream)
    |-> $past(ltssm_state) == LC2_LT_RCV_SPEED || $past(fund_reset) || $past(hot_reset))
    else $error("de-emphasis moved outside speed change");
  tm_clear_a: assert property (
    ltssm_state == LC2_LT_POLL_CFG |=> tx_margin == LC2_TM_NORMAL) else $error("margin kept");
  tm_hold_a: assert property (
    $changed(tx_margin) |-> $past(ltssm_state) inside {LC2_LT_RCV_LOCK, LC2_LT_POLL_CFG}
    || $past(fund_reset)) else $error("margin moved outside lock");
  tm_normal_a: assert property (
    tx_margin_normal == (tx_margin == LC2_TM_NORMAL || tx_margin > LC2_TM_MAX_CODE))
    else $error("normal flag wrong");
endmodule
`default_nettype wire

// *** testbench/link_control2_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_control2_regs_bench;
  import lc2_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  lc2_ltssm_e  ltssm = LC2_LT_L0;
  logic [3:0]  spd = LC2_SPEED_5G0;
  logic        lsw = 1'b0;
  logic [31:0] rd;
  int          errors = 0;
  int          checks_done = 0;
  always #50 clk = ~clk;
  lc2_if lc2_if_inst (.clk(clk), .rst_n(rst_n));
  lc2_regs lc2_regs_inst (.bus(lc2_if_inst));
  lc2_ctrl lc2_ctrl_inst (.link(lc2_if_inst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ltssm_in(ltssm), .cur_speed_in(spd), .low_swing_in(lsw));
  lc2_asserts lc2_asserts_inst (.clk(clk), .rst_n(rst_n), .cfg_addr(lc2_if_inst.cfg_addr),
    .cfg_wr(lc2_if_inst.cfg_wr), .cfg_rd(lc2_if_inst.cfg_rd), .cfg_wdata(lc2_if_inst.cfg_wdata),
    .cfg_rdata(lc2_if_inst.cfg_rdata), .fund_reset(lc2_if_inst.fund_reset),
    .hot_reset(lc2_if_inst.hot_reset), .downstream(lc2_if_inst.downstream),
    .ltssm_state(lc2_if_inst.ltssm_state), .cur_speed(lc2_if_inst.cur_speed),
    .low_swing(lc2_if_inst.low_swing), .adv_max_speed(lc2_if_inst.adv_max_speed),
    .compliance_req(lc2_if_inst.compliance_req),
    .compliance_speed(lc2_if_inst.compliance_speed),
    .tx_deemph_3p5(lc2_if_inst.tx_deemph_3p5), .tx_margin(lc2_if_inst.tx_margin),
    .tx_margin_normal(lc2_if_inst.tx_margin_normal));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe tied to cycle: a classic single cycle raises both together
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (ack !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: no acknowledge", $time);
      stop_test();
    end
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic lt(input lc2_ltssm_e s);
    ltssm <= s;
    @(posedge clk);
    ltssm <= LC2_LT_L0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    xfer(1'b0, LC2_OFF_LCTL2, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    xfer(1'b0, LC2_OFF_LCAP2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_mask();
    xfer(1'b1, LC2_OFF_LCTL2, 32'hffff_fff2);
    xfer(1'b0, LC2_OFF_LCTL2, 32'h0000_0000);
    chk(rd, 32'h0000_03d2);
    lt(LC2_LT_RCV_LOCK);
    chk(32'(lc2_if_inst.tx_margin_normal), 32'h0000_0001);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0010);
    xfer(1'b0, LC2_OFF_LCTL2, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
  endtask
  task automatic t_speed();
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0008);
    xfer(1'b1, LC2_OFF_LCTL2, 32'h0000_0001);
    chk(32'(lc2_if_inst.adv_max_speed), 32'h0000_0001);
    chk(32'(lc2_if_inst.compliance_speed), 32'h0000_0001);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0000);
    chk(32'(lc2_if_inst.adv_max_speed), 32'h0000_0002);
  endtask
  task automatic t_comp();
    xfer(1'b1, LC2_OFF_LCTL2, 32'h0000_0011);
    chk(32'(lc2_if_inst.compliance_req), 32'h0000_0000);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0001);
    chk(32'(lc2_if_inst.compliance_req), 32'h0000_0001);
    xfer(1'b0, LC2_OFF_LCTL2, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0010);
    chk(32'(lc2_if_inst.compliance_req), 32'h0000_0000);
  endtask
  task automatic t_deemph();
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_0008);
    xfer(1'b1, LC2_OFF_LCTL2, 32'h0000_0042);
    chk(32'(lc2_if_inst.tx_deemph_3p5), 32'h0000_0000);
    chk(32'(lc2_if_inst.adv_deemph_3p5), 32'h0000_0001);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_000c);
    lt(LC2_LT_RCV_SPEED);
    chk(32'(lc2_if_inst.tx_deemph_3p5), 32'h0000_0001);
    lsw <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(lc2_if_inst.tx_deemph_3p5), 32'h0000_0000);
    lsw <= 1'b0;
    spd <= LC2_SPEED_2G5;
    @(posedge clk);
    @(posedge clk);
    chk(32'(lc2_if_inst.tx_deemph_3p5), 32'h0000_0000);
    spd <= LC2_SPEED_5G0;
    @(posedge clk);
    xfer(1'b1, LC2_OFF_LCTL2, 32'h0000_0002);
    lt(LC2_LT_RCV_LOCK);
    chk(32'(lc2_if_inst.tx_deemph_3p5), 32'h0000_0001);
  endtask
  task automatic t_margin();
    xfer(1'b1, LC2_OFF_LCTL2, 32'h0000_0182);
    xfer(1'b1, LC2_OFF_PHY_CTRL, 32'h0000_000a);
    lt(LC2_LT_RCV_SPEED);
    chk(32'(lc2_if_inst.tx_margin), 32'h0000_0000);
    lt(LC2_LT_RCV_LOCK);
    chk(32'(lc2_if_inst.tx_margin), 32'h0000_0003);
    chk(32'(lc2_if_inst.tx_margin_normal), 32'h0000_0000);
    lt(LC2_LT_POLL_CFG);
    chk(32'(lc2_if_inst.tx_margin), 32'h0000_0000);
    xfer(1'b0, LC2_OFF_LCTL2, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mask();
    t_speed();
    t_comp();
    t_deemph();
    t_margin();
    stop_test();
  end
endmodule
`default_nettype wire

// *** verilog/lc2_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module lc2_ctrl
  import lc2_pkg::*;
(
  lc2_if.host             link,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  wire lc2_ltssm_e ltssm_in,
  input  wire logic [3:0] cur_speed_in,
  input  wire logic       low_swing_in
);
  typedef enum logic [1:0] {
    LC2_C_IDLE = 2'b00,
    LC2_C_RUN  = 2'b01,
    LC2_C_ACK  = 2'b11
  } lc2_cst_e;
  lc2_cst_e    state;
  logic [4:0]  phy_ctrl;
  logic        wr_q;
  logic        rd_q;
  logic        req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Register-bank accesses take one cycle; read data returns a cycle later
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      state <= LC2_C_IDLE;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state)
        LC2_C_IDLE: if (req) begin
          state <= LC2_C_RUN;
          wr_q  <= wb_we_i && wb_adr_i != LC2_OFF_PHY_CTRL && wb_adr_i != LC2_OFF_PHY_STAT;
          rd_q  <= !wb_we_i;
        end
        LC2_C_RUN: state <= LC2_C_ACK;
        LC2_C_ACK: state <= LC2_C_IDLE;
        default:   state <= LC2_C_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      // Wait for the bank's registered read data before acknowledging
      wb_ack_o <= (state == LC2_C_ACK);
      if (state == LC2_C_ACK) begin
        case (wb_adr_i)
          LC2_OFF_PHY_CTRL: wb_dat_o <= {27'h000_0000, phy_ctrl};
          LC2_OFF_PHY_STAT: wb_dat_o <= {25'h000_0000, cur_speed_in, ltssm_in};
          default:          wb_dat_o <= link.cfg_rdata;
        endcase
      end
    end
  end

  // Reset and retrain controls are pulses; downstream is a level
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      phy_ctrl <= 5'h00;
    end else begin
      phy_ctrl[LC2_PC_HOT_RESET]    <= 1'b0;
      phy_ctrl[LC2_PC_RETRAIN]      <= 1'b0;
      phy_ctrl[LC2_PC_FULL_RETRAIN] <= 1'b0;
      phy_ctrl[LC2_PC_FUND_RESET]   <= 1'b0;
      if (state == LC2_C_IDLE && req && wb_we_i && wb_adr_i == LC2_OFF_PHY_CTRL
          && wb_sel_i[0]) begin
        phy_ctrl <= wb_dat_i[4:0];
      end
    end
  end

  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      link.cfg_addr  <= 8'h00;
      link.cfg_wdata <= 16'h0000;
    end else if (state == LC2_C_IDLE && req) begin
      link.cfg_addr  <= wb_adr_i;
      // Unsupported speeds are software's to avoid; reserved margin codes are replaced by the normal code at the output
      link.cfg_wdata <= wb_dat_i[15:0] & LC2_LCTL2_WMASK;
    end
  end

  assign link.cfg_wr       = wr_q;
  assign link.cfg_rd       = rd_q;
  assign link.hot_reset    = phy_ctrl[LC2_PC_HOT_RESET];
  assign link.retrain      = phy_ctrl[LC2_PC_RETRAIN];
  assign link.full_retrain = phy_ctrl[LC2_PC_FULL_RETRAIN];
  assign link.downstream   = phy_ctrl[LC2_PC_DOWNSTREAM];
  assign link.fund_reset   = phy_ctrl[LC2_PC_FUND_RESET];
  assign link.ltssm_state  = ltssm_in;
  assign link.cur_speed    = cur_speed_in;
  assign link.low_swing    = low_swing_in;
endmodule
`default_nettype wire

// *** verilog/lc2_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lc2_if (
  input wire logic clk,
  input wire logic rst_n
);
  import lc2_pkg::*;
  logic [7:0]  cfg_addr;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [15:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        fund_reset;
  logic        hot_reset;
  logic        retrain;
  logic        full_retrain;
  logic        downstream;
  lc2_ltssm_e  ltssm_state;
  logic [3:0]  cur_speed;
  logic        low_swing;
  logic [3:0]  adv_max_speed;
  logic        compliance_req;
  logic [3:0]  compliance_speed;
  logic        tx_deemph_3p5;
  logic        adv_deemph_3p5;
  logic [2:0]  tx_margin;
  logic        tx_margin_normal;
  modport device (
    input  clk, rst_n, cfg_addr, cfg_wr, cfg_rd, cfg_wdata, fund_reset, hot_reset, retrain,
    input  full_retrain, downstream, ltssm_state, cur_speed, low_swing,
    output cfg_rdata, adv_max_speed, compliance_req, compliance_speed, tx_deemph_3p5,
    output adv_deemph_3p5, tx_margin, tx_margin_normal
  );
  modport host (
    input  clk, rst_n, cfg_rdata, adv_max_speed, compliance_req, compliance_speed,
    input  tx_deemph_3p5, adv_deemph_3p5, tx_margin, tx_margin_normal,
    output cfg_addr, cfg_wr, cfg_rd, cfg_wdata, fund_reset, hot_reset, retrain,
    output full_retrain, downstream, ltssm_state, cur_speed, low_swing
  );
endinterface
`default_nettype wire

// *** verilog/lc2_pkg.sv ***
package lc2_pkg;
  localparam logic [7:0]  LC2_OFF_LCAP2      = 8'h6c;
  localparam logic [7:0]  LC2_OFF_LCTL2      = 8'h70;
  localparam logic [7:0]  LC2_OFF_PHY_CTRL   = 8'h80;
  localparam logic [7:0]  LC2_OFF_PHY_STAT   = 8'h84;
  localparam int          LC2_TS_LSB         = 0;
  localparam int          LC2_TS_MSB         = 3;
  localparam int          LC2_CE_BIT         = 4;
  localparam int          LC2_ASD_BIT        = 5;
  localparam int          LC2_DE_BIT         = 6;
  localparam int          LC2_TM_LSB         = 7;
  localparam int          LC2_TM_MSB         = 9;
  localparam logic [3:0]  LC2_SPEED_2G5      = 4'h1;
  localparam logic [3:0]  LC2_SPEED_5G0      = 4'h2;
  localparam logic [3:0]  LC2_TS_RESET       = 4'h2;
  localparam logic [2:0]  LC2_TM_NORMAL      = 3'h0;
  localparam logic [2:0]  LC2_TM_MAX_CODE    = 3'h5;
  localparam logic [31:0] LC2_LCAP2_RESET    = 32'h0000_0000;
  localparam logic [15:0] LC2_LCTL2_WMASK    = 16'h03df;
  localparam int          LC2_PC_HOT_RESET   = 0;
  localparam int          LC2_PC_RETRAIN     = 1;
  localparam int          LC2_PC_FULL_RETRAIN = 2;
  localparam int          LC2_PC_DOWNSTREAM  = 3;
  localparam int          LC2_PC_FUND_RESET  = 4;
  // Training-sequencer states seen by the register bank
  typedef enum logic [2:0] {
    LC2_LT_DETECT      = 3'b000,
    LC2_LT_POLL_CFG    = 3'b001,
    LC2_LT_L0          = 3'b011,
    LC2_LT_RCV_LOCK    = 3'b010,
    LC2_LT_RCV_SPEED   = 3'b110,
    LC2_LT_COMPLIANCE  = 3'b111
  } lc2_ltssm_e;
endpackage

// *** verilog/lc2_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module lc2_regs
  import lc2_pkg::*;
(
  lc2_if.device bus
);
  logic [3:0]  target_speed;
  logic        compliance_entry;
  logic        deemphasis_select;
  logic [2:0]  transmit_margin;
  logic        deemph_active;
  logic [2:0]  margin_active;
  logic        comp_armed;
  lc2_ltssm_e  prev_state;
  logic [15:0] lctl2_view;

  function automatic logic is_write(input logic [7:0] off);
    is_write = bus.cfg_wr && (bus.cfg_addr == off);
  endfunction

  // Sticky fields: only fundamental reset restores them
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      target_speed     <= LC2_TS_RESET;
      compliance_entry <= 1'b0;
    end else if (bus.fund_reset) begin
      target_speed     <= LC2_TS_RESET;
      compliance_entry <= 1'b0;
    end else if (is_write(LC2_OFF_LCTL2)) begin
      target_speed     <= bus.cfg_wdata[LC2_TS_MSB:LC2_TS_LSB];
      compliance_entry <= bus.cfg_wdata[LC2_CE_BIT];
    end
  end

  // Margin: hardware clear on Polling.Configuration entry wins over a write
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      transmit_margin <= LC2_TM_NORMAL;
    end else if (bus.fund_reset) begin
      transmit_margin <= LC2_TM_NORMAL;
    end else if (bus.ltssm_state == LC2_LT_POLL_CFG && prev_state != LC2_LT_POLL_CFG) begin
      transmit_margin <= LC2_TM_NORMAL;
    end else if (is_write(LC2_OFF_LCTL2)) begin
      transmit_margin <= bus.cfg_wdata[LC2_TM_MSB:LC2_TM_LSB];
    end
  end

  // Non-sticky: any reset of the port clears it
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      deemphasis_select <= 1'b0;
    end else if (bus.fund_reset || bus.hot_reset) begin
      deemphasis_select <= 1'b0;
    end else if (is_write(LC2_OFF_LCTL2)) begin
      deemphasis_select <= bus.cfg_wdata[LC2_DE_BIT];
    end
  end

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      prev_state <= LC2_LT_DETECT;
    end else begin
      prev_state <= bus.ltssm_state;
    end
  end

  // Line settings latch only in the states allowed to change them
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      deemph_active <= 1'b0;
    end else if (bus.ltssm_state == LC2_LT_RCV_SPEED) begin
      deemph_active <= deemphasis_select;
    end
  end

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      margin_active <= LC2_TM_NORMAL;
    end else if (bus.ltssm_state == LC2_LT_POLL_CFG) begin
      margin_active <= LC2_TM_NORMAL;
    end else if (bus.ltssm_state == LC2_LT_RCV_LOCK) begin
      margin_active <= transmit_margin;
    end
  end

  // Compliance armed by bit; taken at the hot reset that follows
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      comp_armed <= 1'b0;
    end else if (bus.fund_reset || !compliance_entry) begin
      comp_armed <= 1'b0;
    end else if (bus.hot_reset) begin
      comp_armed <= 1'b1;
    end
  end

  assign bus.compliance_req   = comp_armed;
  assign bus.compliance_speed = target_speed;
  // Upstream ports advertise everything; the partner caps them
  assign bus.adv_max_speed    = bus.downstream ? target_speed : LC2_SPEED_5G0;
  // Fixed at -6 dB when de-emphasis is irrelevant on the line
  assign bus.tx_deemph_3p5    = bus.downstream && deemph_active
                                && bus.cur_speed == LC2_SPEED_5G0 && !bus.low_swing;
  assign bus.adv_deemph_3p5   = deemphasis_select;
  // Reserved codes are driven out as the normal code
  assign bus.tx_margin        = (margin_active > LC2_TM_MAX_CODE) ? LC2_TM_NORMAL
                                : margin_active;
  assign bus.tx_margin_normal = (bus.tx_margin == LC2_TM_NORMAL);

  always_comb begin
    lctl2_view = 16'h0000;
    lctl2_view[LC2_TS_MSB:LC2_TS_LSB] = target_speed;
    lctl2_view[LC2_CE_BIT]            = compliance_entry;
    lctl2_view[LC2_ASD_BIT]           = 1'b0;
    lctl2_view[LC2_DE_BIT]            = deemphasis_select;
    lctl2_view[LC2_TM_MSB:LC2_TM_LSB] = transmit_margin;
  end

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.cfg_rdata <= 32'h0000_0000;
    end else if (bus.cfg_rd) begin
      case (bus.cfg_addr)
        LC2_OFF_LCAP2: bus.cfg_rdata <= LC2_LCAP2_RESET;
        LC2_OFF_LCTL2: bus.cfg_rdata <= {16'h0000, lctl2_view};
        default:       bus.cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire
